// [core/bmem_map.svh]
// Purpose: Offsets, field positions, reset values for the block memory
// Assumes: AXI4-Lite register window, 32-bit data
// Notes:   Definitions only
`ifndef BMEM_MAP_SVH
`define BMEM_MAP_SVH

// ==========================================================
// Register offsets (byte addresses)
`define BMEM_CTRL_OFS 4'h0
`define BMEM_STAT_OFS 4'h4
`define BMEM_OFS_W 4

// ==========================================================
// Control fields: port A in byte 0, port B in byte 1
`define BMEM_A_OUTREG_BIT 0
`define BMEM_A_WTHRU_BIT 1
`define BMEM_A_ASYNC_BIT 2
`define BMEM_B_OUTREG_BIT 8
`define BMEM_B_WTHRU_BIT 9
`define BMEM_B_ASYNC_BIT 10
`define BMEM_CTRL_MASK 32'h0000_0707
`define BMEM_CTRL_RST 32'h0000_0000

// ==========================================================
// Status fields: write counters
`define BMEM_STAT_A_LSB 0
`define BMEM_STAT_B_LSB 16
`define BMEM_CNT_W 16

// ==========================================================
// Bus answers
`define BMEM_RESP_OKAY 2'h0
`define BMEM_RESP_SLVERR 2'h2

// ==========================================================
// Default geometry
`define BMEM_ADDR_W 9
`define BMEM_DATA_W 18

`endif

// [core/bmem_out_stage.sv]
// Purpose: Output latch and optional output register of one port
// Assumes: Read and write strobes come from the port's input registers
// Notes:   Clear source may act with or without the clock
`timescale 1ns/1ps
`include "bmem_map.svh"
module bmem_out_stage
	import bmem_pkg::*;
#(
	parameter int DATA_W = `BMEM_DATA_W
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire bmem_port_cfg_s cfg,
	input wire logic clr,
	input wire logic rd_en,
	input wire logic wr_en,
	input wire logic [DATA_W-1:0] rd_data,
	input wire logic [DATA_W-1:0] wr_data,
	output logic [DATA_W-1:0] dout
);

	// ==========================================================
	// Clear selection
	logic [DATA_W-1:0] latch_ff;
	logic [DATA_W-1:0] nxt_latch;
	logic [DATA_W-1:0] nxt_dout;
	wire clr_async = clr & cfg.async_rst;
	wire clr_sync = clr & ~cfg.async_rst;

	// ==========================================================
	// Next values
	// Normal mode holds the latch on a write; write-through shows wr_data
	assign nxt_latch = rd_en ? rd_data :
		(wr_en & cfg.wthru) ? wr_data :
		latch_ff;
	// Bypass loads what the latch loads, so dout stays a flop output
	assign nxt_dout = cfg.outreg ? latch_ff : nxt_latch;

	// ==========================================================
	// Latch and output register
	always_ff @(posedge aclk or posedge clr_async) begin
		if (clr_async) begin
			latch_ff <= '0;
			dout <= '0;
		end else if (!aresetn || clr_sync) begin
			latch_ff <= '0;
			dout <= '0;
		end else begin
			latch_ff <= nxt_latch;
			dout <= nxt_dout;
		end
	end

endmodule // bmem_out_stage

// [core/bmem_pkg.sv]
// Purpose: Types shared by the block memory files
// Assumes: Nothing beyond the map header
// Notes:   Per-port configuration travels as one struct
package bmem_pkg;

	// ==========================================================
	// Port configuration
	typedef struct packed {
		logic async_rst;
		logic wthru;
		logic outreg;
	} bmem_port_cfg_s;

endpackage

// [core/bmem_top.sv]
// Purpose: Two-port block memory with AXI4-Lite configuration window
// Assumes: Both ports and the bus share aclk; user logic is synchronous
// Notes:   Simultaneous writes to one address from both ports: B wins
`timescale 1ns/1ps
`include "bmem_map.svh"

// Functional notes
// - Each port registers address, data and strobes before the array.
// - Output register per port is optional; bypass shows latch data.
// - Each port selects normal or write-through write behaviour.
// - Normal mode: output changes on reads only, never on writes.
// - Write-through: written data also appears on that port's output.
// - Output latch clear is asynchronous or synchronous by configuration.
// - Local reset of a port clears only that port's output.
// - Active-low global reset clears both port outputs.
module bmem_top
	import bmem_pkg::*;
#(
	parameter int ADDR_W = `BMEM_ADDR_W,
	parameter int DATA_W = `BMEM_DATA_W
) (
	input wire logic aclk,
	input wire logic aresetn,
	// Register bus
	input wire logic [31:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [31:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Resets of the output latches
	input wire logic global_reset_n,
	input wire logic port_a_output_reset,
	input wire logic port_b_output_reset,
	// Port A
	input wire logic a_cs,
	input wire logic a_we,
	input wire logic [ADDR_W-1:0] a_addr,
	input wire logic [DATA_W-1:0] a_din,
	output logic [DATA_W-1:0] a_dout,
	// Port B
	input wire logic b_cs,
	input wire logic b_we,
	input wire logic [ADDR_W-1:0] b_addr,
	input wire logic [DATA_W-1:0] b_din,
	output logic [DATA_W-1:0] b_dout
);

	// ==========================================================
	// Elaboration checks
	if (ADDR_W < 1 || ADDR_W > 16) begin : g_addr_w_bad
		$error("bmem_top: ADDR_W out of range");
	end
	if (DATA_W < 1 || DATA_W > 72) begin : g_data_w_bad
		$error("bmem_top: DATA_W out of range");
	end

	localparam int DEPTH = 2 ** ADDR_W;

	// ==========================================================
	// Input registers
	logic a_cs_ff, a_we_ff, b_cs_ff, b_we_ff;
	logic [ADDR_W-1:0] a_addr_ff, b_addr_ff;
	logic [DATA_W-1:0] a_din_ff, b_din_ff;

	// The user holds all four together for the edge
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			a_cs_ff <= 1'b0;
			a_we_ff <= 1'b0;
			b_cs_ff <= 1'b0;
			b_we_ff <= 1'b0;
		end else begin
			a_cs_ff <= a_cs;
			a_we_ff <= a_we;
			b_cs_ff <= b_cs;
			b_we_ff <= b_we;
		end
	end

	// Address and data need no reset: the strobes gate them
	always_ff @(posedge aclk) begin
		a_addr_ff <= a_addr;
		a_din_ff <= a_din;
		b_addr_ff <= b_addr;
		b_din_ff <= b_din;
	end

	// ==========================================================
	// Memory array
	logic [DATA_W-1:0] mem [DEPTH];
	wire a_wr = a_cs_ff & a_we_ff;
	wire a_rd = a_cs_ff & ~a_we_ff;
	wire b_wr = b_cs_ff & b_we_ff;
	wire b_rd = b_cs_ff & ~b_we_ff;
	wire [DATA_W-1:0] a_mem_q = mem[a_addr_ff];
	wire [DATA_W-1:0] b_mem_q = mem[b_addr_ff];

	// A read on one port during a write on the other returns old data
	always_ff @(posedge aclk) begin
		if (a_wr)
			mem[a_addr_ff] <= a_din_ff;
		if (b_wr)
			mem[b_addr_ff] <= b_din_ff;
	end

	// ==========================================================
	// Configuration register
	logic [31:0] ctrl_ff;
	logic [`BMEM_CNT_W-1:0] a_wcnt_ff, b_wcnt_ff;
	bmem_port_cfg_s a_cfg, b_cfg;

	assign a_cfg.outreg = ctrl_ff[`BMEM_A_OUTREG_BIT];
	assign a_cfg.wthru = ctrl_ff[`BMEM_A_WTHRU_BIT];
	assign a_cfg.async_rst = ctrl_ff[`BMEM_A_ASYNC_BIT];
	assign b_cfg.outreg = ctrl_ff[`BMEM_B_OUTREG_BIT];
	assign b_cfg.wthru = ctrl_ff[`BMEM_B_WTHRU_BIT];
	assign b_cfg.async_rst = ctrl_ff[`BMEM_B_ASYNC_BIT];

	// ==========================================================
	// Output stages
	// Global clear reaches both, local clear only its own port
	wire a_clr = port_a_output_reset | ~global_reset_n;
	wire b_clr = port_b_output_reset | ~global_reset_n;

	bmem_out_stage #(
		.DATA_W(DATA_W)
	) u_out_a (
		.aclk(aclk),
		.aresetn(aresetn),
		.cfg(a_cfg),
		.clr(a_clr),
		.rd_en(a_rd),
		.wr_en(a_wr),
		.rd_data(a_mem_q),
		.wr_data(a_din_ff),
		.dout(a_dout)
	);

	bmem_out_stage #(
		.DATA_W(DATA_W)
	) u_out_b (
		.aclk(aclk),
		.aresetn(aresetn),
		.cfg(b_cfg),
		.clr(b_clr),
		.rd_en(b_rd),
		.wr_en(b_wr),
		.rd_data(b_mem_q),
		.wr_data(b_din_ff),
		.dout(b_dout)
	);

	// ==========================================================
	// Write counters, wrap at full scale
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			a_wcnt_ff <= '0;
			b_wcnt_ff <= '0;
		end else begin
			if (a_wr)
				a_wcnt_ff <= a_wcnt_ff + 1'b1;
			if (b_wr)
				b_wcnt_ff <= b_wcnt_ff + 1'b1;
		end
	end

	// ==========================================================
	// AXI4-Lite write channel
	logic aw_have_ff, w_have_ff;
	logic [`BMEM_OFS_W-1:0] awaddr_ff;
	logic [31:0] wdata_ff;
	logic [3:0] wstrb_ff;
	logic [31:0] nxt_ctrl;
	logic [31:0] strb_mask;

	wire aw_hs = s_axi_awvalid & s_axi_awready;
	wire w_hs = s_axi_wvalid & s_axi_wready;
	wire b_hs = s_axi_bvalid & s_axi_bready;
	wire wr_go = aw_have_ff & w_have_ff & ~s_axi_bvalid;
	wire wr_ctrl = awaddr_ff == `BMEM_CTRL_OFS;
	wire wr_stat = awaddr_ff == `BMEM_STAT_OFS;
	wire wr_hit = wr_ctrl | wr_stat;

	assign strb_mask = {{8{wstrb_ff[3]}}, {8{wstrb_ff[2]}},
		{8{wstrb_ff[1]}}, {8{wstrb_ff[0]}}};
	assign nxt_ctrl = ((ctrl_ff & ~strb_mask) | (wdata_ff & strb_mask))
		& `BMEM_CTRL_MASK;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			aw_have_ff <= 1'b0;
			w_have_ff <= 1'b0;
			awaddr_ff <= '0;
			wdata_ff <= '0;
			wstrb_ff <= '0;
		end else begin
			if (aw_hs) begin
				s_axi_awready <= 1'b0;
				aw_have_ff <= 1'b1;
				awaddr_ff <= s_axi_awaddr[`BMEM_OFS_W-1:0];
			end else if (wr_go) begin
				aw_have_ff <= 1'b0;
			end else if (b_hs) begin
				s_axi_awready <= 1'b1;
			end
			if (w_hs) begin
				s_axi_wready <= 1'b0;
				w_have_ff <= 1'b1;
				wdata_ff <= s_axi_wdata;
				wstrb_ff <= s_axi_wstrb;
			end else if (wr_go) begin
				w_have_ff <= 1'b0;
			end else if (b_hs) begin
				s_axi_wready <= 1'b1;
			end
		end
	end

	// Status is read-only; writing it is accepted and ignored
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_ff <= `BMEM_CTRL_RST;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `BMEM_RESP_OKAY;
		end else begin
			if (wr_go && wr_ctrl)
				ctrl_ff <= nxt_ctrl;
			if (wr_go) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_hit ? `BMEM_RESP_OKAY : `BMEM_RESP_SLVERR;
			end else if (b_hs) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// ==========================================================
	// AXI4-Lite read channel
	wire ar_hs = s_axi_arvalid & s_axi_arready;
	wire r_hs = s_axi_rvalid & s_axi_rready;
	wire [`BMEM_OFS_W-1:0] rd_ofs = s_axi_araddr[`BMEM_OFS_W-1:0];
	wire rd_ctrl = rd_ofs == `BMEM_CTRL_OFS;
	wire rd_stat = rd_ofs == `BMEM_STAT_OFS;
	wire [31:0] stat_word = {b_wcnt_ff, a_wcnt_ff};
	wire [31:0] rd_word = rd_ctrl ? ctrl_ff : rd_stat ? stat_word : 32'h0;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0;
			s_axi_rresp <= `BMEM_RESP_OKAY;
		end else if (ar_hs) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rd_word;
			s_axi_rresp <= (rd_ctrl | rd_stat) ? `BMEM_RESP_OKAY
				: `BMEM_RESP_SLVERR;
		end else if (r_hs) begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

endmodule // bmem_top

// [tb/bmem_props.sv]
// Purpose: Port-level checks of the block memory
// Assumes: Single clock aclk, synchronous aresetn
// Notes:   Config bits are internal, so checks hold in every mode
`timescale 1ns/1ps
`include "bmem_map.svh"
module bmem_props #(
	parameter int DATA_W = `BMEM_DATA_W
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_awready,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic global_reset_n,
	input wire logic port_a_output_reset,
	input wire logic port_b_output_reset,
	input wire logic a_cs,
	input wire logic b_cs,
	input wire logic [DATA_W-1:0] a_dout,
	input wire logic [DATA_W-1:0] b_dout
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// ==========================================================
	// Checks; an async clear moves dout before it is sampled
	logic a_ok;
	logic b_ok;
	assign a_ok = global_reset_n && !port_a_output_reset;
	assign b_ok = global_reset_n && !port_b_output_reset;
	// Three idle samples: the output register lags a read by one more edge
	chk_a_hold: assert property (
		(!a_cs && a_ok) [*3] |=> $stable(a_dout) || !a_ok)
		else $error("A output moved without access");
	chk_b_hold: assert property (
		(!b_cs && b_ok) [*3] |=> $stable(b_dout) || !b_ok)
		else $error("B output moved without access");
	chk_a_clear: assert property (
		port_a_output_reset |=> a_dout == '0) else $error("A not cleared");
	chk_b_clear: assert property (
		port_b_output_reset |=> b_dout == '0) else $error("B not cleared");
	chk_both_clear: assert property (
		!global_reset_n |=> a_dout == '0 && b_dout == '0)
		else $error("Global clear missed");
	chk_aw_block: assert property (
		s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("Write accepted while busy");
	chk_rd_answer: assert property (
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
		else $error("Read answer late");
	chk_wr_done: assert property (
		s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready)
		else $error("Write response not retired");
endmodule // bmem_props
bind bmem_top bmem_props #(.DATA_W(DATA_W)) u_props (
	.aclk(aclk),
	.aresetn(aresetn),
	.s_axi_awready(s_axi_awready),
	.s_axi_wready(s_axi_wready),
	.s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready),
	.s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready),
	.s_axi_rvalid(s_axi_rvalid),
	.global_reset_n(global_reset_n),
	.port_a_output_reset(port_a_output_reset),
	.port_b_output_reset(port_b_output_reset),
	.a_cs(a_cs),
	.b_cs(b_cs),
	.a_dout(a_dout),
	.b_dout(b_dout)
);

// [tb/bmem_user.sv]
// Purpose: User fabric model driving both memory ports
// Assumes: One access per call; a port idles between calls
// Notes:   Idle ports show inverted leftovers, so stale values return on every other call
`timescale 1ns/1ps
`include "bmem_map.svh"
module bmem_user (
	input wire logic aclk,
	output logic a_cs,
	output logic a_we,
	output logic [`BMEM_ADDR_W-1:0] a_addr,
	output logic [`BMEM_DATA_W-1:0] a_din,
	output logic b_cs,
	output logic b_we,
	output logic [`BMEM_ADDR_W-1:0] b_addr,
	output logic [`BMEM_DATA_W-1:0] b_din
);
	// ==========================================================
	// Access
	initial begin
		{a_cs, a_we, a_addr, a_din} = '0;
		{b_cs, b_we, b_addr, b_din} = '0;
	end
	task automatic acc(input bit p, input bit we,
		input logic [`BMEM_ADDR_W-1:0] ad, input logic [`BMEM_DATA_W-1:0] d);
		@(posedge aclk);
		if (p) {b_cs, b_we, b_addr, b_din} <= {1'b1, we, ad, d};
		else {a_cs, a_we, a_addr, a_din} <= {1'b1, we, ad, d};
		@(posedge aclk);
		// Scrambled so a design that reads late sees garbage
		{a_cs, a_we, a_addr, a_din} <= {1'b0, ~a_we, ~a_addr, ~a_din};
		{b_cs, b_we, b_addr, b_din} <= {1'b0, ~b_we, ~b_addr, ~b_din};
	endtask
endmodule // bmem_user

// [tb/testbench.sv]
// Purpose: Self-checking bench for the two-port block memory
// Assumes: Ports and register bus share aclk
// Notes:   Port stimulus comes from the user fabric model
`timescale 1ns/1ps
`include "bmem_map.svh"
module testbench;
	logic aclk = 1'b0, aresetn = 1'b0, global_reset_n = 1'b1;
	logic port_a_output_reset = 1'b0, port_b_output_reset = 1'b0;
	logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid;
	logic s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata;
	logic a_cs, a_we, b_cs, b_we;
	logic [`BMEM_ADDR_W-1:0] a_addr, b_addr;
	logic [`BMEM_DATA_W-1:0] a_din, b_din, a_dout, b_dout;
	int bad_count = 0, comparisons = 0, cyc = 0;
	localparam logic [17:0] v5 = 18'h2_1234, v7 = 18'h3_0f0f;
	localparam logic [17:0] v8 = 18'h1_5a5a;
	localparam logic [31:0] ofs_c = `BMEM_CTRL_OFS, ofs_s = `BMEM_STAT_OFS;
	bmem_top dut (.*);
	bmem_user u_usr (.*);
	always #20 aclk = ~aclk;
	// ==========================================================
	// Helpers
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			bad_count++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic end_of_test;
		$display("Comparisons %0d, mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	task automatic axw(input logic [31:0] ad, d, input logic [1:0] r);
		@(posedge aclk);
		s_axi_awaddr <= ad;
		s_axi_wdata <= d;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		s_axi_bready <= 1'b0;
		chk(s_axi_bresp, r);
	endtask
	task automatic axr(input logic [31:0] ad, e, input logic [1:0] r);
		@(posedge aclk);
		s_axi_araddr <= ad;
		{s_axi_arvalid, s_axi_rready} <= 2'h3;
		do begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		s_axi_rready <= 1'b0;
		chk(s_axi_rdata, e);
		chk(s_axi_rresp, r);
	endtask
	// Read, then check each edge: old value until the last, new at it
	task automatic rd(input bit p, input logic [8:0] ad,
		input logic [31:0] o, e, input int n);
		u_usr.acc(p, 1'b0, ad, '0);
		for (int i = 1; i <= n; i++) begin
			@(posedge aclk);
			#1;
			chk(p ? b_dout : a_dout, i == n ? e : o);
		end
	endtask
	task automatic idle(input int n);
		repeat (n) @(posedge aclk);
		#1;
	endtask
	// ==========================================================
	// Scenarios
	task automatic t_regs;
		chk(a_dout, '0);
		chk(b_dout, '0);
		axr(ofs_c, `BMEM_CTRL_RST, `BMEM_RESP_OKAY);
		axr(ofs_s, 32'h0, `BMEM_RESP_OKAY);
		axw(ofs_c, 32'hffff_ffff, `BMEM_RESP_OKAY);
		axr(ofs_c, `BMEM_CTRL_MASK, `BMEM_RESP_OKAY);
		axw(32'h8, 32'h1, `BMEM_RESP_SLVERR);
		axr(32'hc, 32'h0, `BMEM_RESP_SLVERR);
		axw(ofs_c, 32'h0, `BMEM_RESP_OKAY);
	endtask
	task automatic t_normal;
		u_usr.acc(1'b0, 1'b1, 9'h5, v5);
		idle(2);
		chk(a_dout, '0);
		rd(1'b0, 9'h5, 32'h0, v5, 1);
		rd(1'b1, 9'h5, 32'h0, v5, 1);
	endtask
	task automatic t_wthru;
		axw(ofs_c, 32'h2, `BMEM_RESP_OKAY);
		u_usr.acc(1'b0, 1'b1, 9'h7, v7);
		idle(1);
		chk(a_dout, v7);
		u_usr.acc(1'b1, 1'b1, 9'h8, v8);
		idle(2);
		chk(b_dout, v5);
		axw(ofs_c, 32'h103, `BMEM_RESP_OKAY);
		rd(1'b0, 9'h8, v7, v8, 2);
		rd(1'b1, 9'h7, v5, v7, 2);
	endtask
	task automatic t_clear;
		@(posedge aclk) port_a_output_reset <= 1'b1;
		#1 chk(a_dout, v8);
		@(posedge aclk) port_a_output_reset <= 1'b0;
		#1 chk(a_dout, '0);
		chk(b_dout, v7);
		axw(ofs_c, 32'h400, `BMEM_RESP_OKAY);
		@(posedge aclk) port_b_output_reset <= 1'b1;
		#1 chk(b_dout, '0);
		@(posedge aclk) port_b_output_reset <= 1'b0;
		rd(1'b0, 9'h5, 32'h0, v5, 1);
		rd(1'b1, 9'h8, 32'h0, v8, 1);
		@(posedge aclk) global_reset_n <= 1'b0;
		@(posedge aclk) global_reset_n <= 1'b1;
		#1 chk(a_dout, '0);
		chk(b_dout, '0);
		axr(ofs_s, 32'h0001_0002, `BMEM_RESP_OKAY);
		axw(ofs_s, 32'hffff_ffff, `BMEM_RESP_OKAY);
		axr(ofs_s, 32'h0001_0002, `BMEM_RESP_OKAY);
		// Port B write-through and port A clock-free clear
		axw(ofs_c, 32'h204, `BMEM_RESP_OKAY);
		u_usr.acc(1'b1, 1'b1, 9'h9, v8);
		idle(1);
		chk(b_dout, v8);
		rd(1'b0, 9'h5, 32'h0, v5, 1);
		@(posedge aclk) port_a_output_reset <= 1'b1;
		#1 chk(a_dout, '0);
		chk(b_dout, v8);
		@(posedge aclk) port_a_output_reset <= 1'b0;
	endtask
	initial begin
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		t_regs();
		t_normal();
		t_wthru();
		t_clear();
		end_of_test();
	end
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			bad_count++;
			end_of_test();
		end
	end
endmodule // testbench
